// File: logic/linear_sensor_scan_timing.v
`include "scan_timing_defines.vh"
`default_nettype none
module linear_sensor_scan_timing #(
   parameter PIXELS = `PIXEL_COUNT,
   parameter IDX_W = 10,
   parameter PIXEL_W = `PIXEL_W,
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire core_clk,
   input wire reset_n,
   input wire phase1_in,
   input wire phase2_in,
   input wire scan_start_pulse,
   input wire line_reset_in,
   input wire overflow_gate_in,
   input wire [PIXEL_W-1:0] pixel_level,
   output reg [IDX_W-1:0] pixel_addr_q,
   output reg addr_on_q,
   output reg scan_done_n_q,
   output reg scan_done_oe_n_q,
   output reg line_clamped_q,
   output reg pixels_held_reset_q,
   output reg pixel_clear_q,
   output reg [IDX_W-1:0] clear_addr_q,
   output reg video_valid_q,
   output reg [PIXEL_W-1:0] video_q,
   input wire video_ready,
   output reg overrun_q
);
   // sensor control pins live outside this clock: two flops each before any use; pixel_level goes to the fifo unsynchronised
   reg [4:0] sync1_q;
   reg [4:0] sync2_q;
   reg p2_prev_q;
   reg st_prev_q;
   reg armed_q;
   reg [IDX_W-1:0] next_q;
   reg running_q;
   wire [4:0] pins = {overflow_gate_in, line_reset_in, scan_start_pulse, phase2_in, phase1_in};
   wire st_s = sync2_q[2];
   wire p2_s = sync2_q[1];
   wire p2_rise = p2_s && !p2_prev_q;
   wire p2_fall = !p2_s && p2_prev_q;
   wire f_ready;
   wire f_valid;
   wire [PIXEL_W-1:0] f_data;
   wire f_push = running_q && p2_rise;
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end
   // scan chain: start loads the chain on the first phase-two fall after start rises, or while start is high
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         p2_prev_q <= 1'b0;
         st_prev_q <= 1'b0;
         armed_q <= 1'b0;
         next_q <= {IDX_W{1'b0}};
         running_q <= 1'b0;
         pixel_addr_q <= {IDX_W{1'b0}};
         addr_on_q <= 1'b0;
         scan_done_n_q <= 1'b1;
         scan_done_oe_n_q <= 1'b1;
         pixel_clear_q <= 1'b0;
         clear_addr_q <= {IDX_W{1'b0}};
         overrun_q <= 1'b0;
      end else begin
         p2_prev_q <= p2_s;
         st_prev_q <= st_s;
         pixel_clear_q <= 1'b0;
         if (st_s && !st_prev_q) begin
            armed_q <= 1'b1;
         end
         if (p2_fall && (armed_q || st_s)) begin
            armed_q <= 1'b0;
            running_q <= 1'b1;
            next_q <= {IDX_W{1'b0}};
         end
         // end-of-scan is open drain: pull low, otherwise release
         if (p2_fall && scan_done_oe_n_q == 1'b0) begin
            scan_done_n_q <= 1'b1;
            scan_done_oe_n_q <= 1'b1;
         end
         if (f_push) begin
            pixel_addr_q <= next_q;
            addr_on_q <= 1'b1;
            pixel_clear_q <= 1'b1;
            clear_addr_q <= next_q;
            if (!f_ready) begin
               overrun_q <= 1'b1;
            end
            if (next_q == PIXELS[IDX_W-1:0] - 1'b1 || PIXELS == (1 << IDX_W) && &next_q) begin
               running_q <= 1'b0;
               scan_done_n_q <= 1'b0;
               scan_done_oe_n_q <= 1'b0;
            end else begin
               next_q <= next_q + 1'b1;
            end
         end else if (p2_fall) begin
            addr_on_q <= 1'b0;
         end
      end
   end
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         line_clamped_q <= 1'b0;
         pixels_held_reset_q <= 1'b0;
      end else begin
         line_clamped_q <= sync2_q[3];
         pixels_held_reset_q <= sync2_q[4];
      end
   end
   // a full fifo drops the pixel and flags overrun; the sensor cannot be stalled
   pixel_fifo #(
      .WIDTH(PIXEL_W),
      .DEPTH(FIFO_DEPTH),
      .AW(5)
   ) u_fifo (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(f_push),
      .in_ready(f_ready),
      .in_data(pixels_held_reset_q ? {PIXEL_W{1'b0}} : pixel_level),
      .out_valid(f_valid),
      .out_ready(video_ready && (!video_valid_q || video_ready)),
      .out_data(f_data)
   );
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         video_valid_q <= 1'b0;
         video_q <= {PIXEL_W{1'b0}};
      end else if (!video_valid_q || video_ready) begin
         video_valid_q <= f_valid && video_ready;
         video_q <= f_data;
      end
   end
endmodule
`default_nettype wire

// File: logic/pixel_fifo.v
`default_nettype none
module pixel_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire core_clk,
   input wire reset_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rd_q];
   always @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: logic/scan_timing_defines.vh
// Summary of operation
// - start and phase two advance pixel scan chain
// - one pixel per phase-two rising edge
// - start high begins a new scan
// - active-low end-of-scan after last pixel
// - line reset high clamps the video line
// - readout clears each pixel's charge
// - overflow gate high holds all pixels reset
`ifndef SCAN_TIMING_DEFINES_VH
`define SCAN_TIMING_DEFINES_VH
`define PIXEL_COUNT 1024
`define PIXEL_W 8
`define FIFO_DEPTH 32
`define CLK_NS 100
`define PHASE_HIGH_MIN_NS 200
`define PHASE_HIGH_MIN_CYC ((`PHASE_HIGH_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define GRESET_MIN_US 5
`define GRESET_MIN_CYC ((`GRESET_MIN_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`endif

// File: verification/linear_sensor_scan_timing_test.sv
`default_nettype none
module linear_sensor_scan_timing_test;
   timeunit 1ns / 1ns;
   logic core_clk = 0, reset_n = 0, video_ready = 0, done_seen = 0, phase1_in, phase2_in, scan_start_pulse;
   logic line_reset_in, overflow_gate_in, addr_on_q, scan_done_n_q, scan_done_oe_n_q, line_clamped_q;
   logic pixels_held_reset_q, pixel_clear_q, video_valid_q, overrun_q;
   logic [9:0] pixel_addr_q, clear_addr_q;
   logic [7:0] pixel_level, video_q, got[$];
   int failures = 0, cmp_count = 0;
   scan_drv i_scan_drv (.*);
   linear_sensor_scan_timing #(.PIXELS(40)) i_linear_sensor_scan_timing (.*);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (video_valid_q === 1'h1 && video_ready) got.push_back(video_q);
      if (scan_done_n_q === 1'h0) done_seen <= 1'h1;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) failures++;
      if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
   endtask
   task automatic results();
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic drain(input int n);
      repeat (3000) if (got.size() < n) @(posedge core_clk);
      if (got.size() < n) failures++;
      if (got.size() < n) results();
      foreach (got[i]) chk(got[i], 8'hA0 + 8'(i));
      got.delete();
   endtask
   task automatic t_full();
      video_ready <= 1'h1;
      i_scan_drv.scan(40, 0);
      i_scan_drv.tick(20);
      chk(16'(got.size()), 16'h28);
      chk(done_seen, 1'h1);
      drain(40);
   endtask
   task automatic t_hold();
      i_scan_drv.overflow_gate_in <= 1'h1;
      i_scan_drv.tick(60);
      chk(pixels_held_reset_q, 1'h1);
      i_scan_drv.overflow_gate_in <= 1'h0;
      i_scan_drv.tick(5);
      chk(pixels_held_reset_q, 1'h0);
   endtask
   // stalled consumer over a slow scan: the buffer fills, later words drop
   task automatic t_fill();
      video_ready <= 1'h0;
      i_scan_drv.scan(40, 2);
      chk(video_valid_q, 1'h0);
      chk(overrun_q, 1'h1);
      video_ready <= 1'h1;
      drain(32);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'h1;
      i_scan_drv.tick(3);
      t_full();
      t_hold();
      t_fill();
      results();
   end
endmodule
bind linear_sensor_scan_timing scan_asserts #(.PIXELS(PIXELS)) i_scan_asserts (.*);
`default_nettype wire

// File: verification/scan_asserts.sv
`default_nettype none
module scan_asserts #(parameter PIXELS = 40) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic phase2_in,
   input wire logic line_reset_in,
   input wire logic overflow_gate_in,
   input wire logic pixel_clear_q,
   input wire logic [9:0] pixel_addr_q,
   input wire logic [9:0] clear_addr_q,
   input wire logic scan_done_n_q,
   input wire logic scan_done_oe_n_q,
   input wire logic line_clamped_q,
   input wire logic pixels_held_reset_q,
   input wire logic addr_on_q
);
   timeunit 1ns / 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_addr_step: assert property ($changed(pixel_addr_q) |->
      pixel_addr_q == 0 || pixel_addr_q == $past(pixel_addr_q) + 1) else $error("step");
   a_pixel_rate: assert property (pixel_clear_q |->
      $past(phase2_in, 2) ##1 !pixel_clear_q) else $error("rate");
   a_clamp_on: assert property (line_reset_in [*4] |-> line_clamped_q) else $error("clamp");
   a_hold_on: assert property (overflow_gate_in [*4] |-> pixels_held_reset_q) else $error("hold");
   a_clear_addr: assert property (pixel_clear_q |-> clear_addr_q == pixel_addr_q) else $error("clear");
   a_done_last: assert property ($fell(scan_done_n_q) |-> pixel_addr_q == PIXELS - 1) else $error("done");
   a_done_pin: assert property (!scan_done_n_q |-> !scan_done_oe_n_q) else $error("pin");
   a_addr_on: assert property (pixel_clear_q |-> addr_on_q) else $error("switch");
   cover property (!scan_done_n_q);
   cover property (line_clamped_q);
   cover property (pixels_held_reset_q ##1 !pixels_held_reset_q);
endmodule
`default_nettype wire

// File: verification/scan_drv.sv
`default_nettype none
module scan_drv (
   input wire logic core_clk,
   output logic phase1_in,
   output logic phase2_in,
   output logic scan_start_pulse,
   output logic line_reset_in,
   output logic overflow_gate_in,
   output logic [7:0] pixel_level
);
   timeunit 1ns / 1ns;
   initial {phase1_in, phase2_in, scan_start_pulse, line_reset_in, overflow_gate_in, pixel_level} = '0;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // gap 0 swaps phases on one edge, larger gaps separate them
   task automatic period(input int gap, input logic s, input logic [7:0] v);
      phase1_in <= 1'h0;
      tick(gap);
      phase2_in <= 1'h1;
      scan_start_pulse <= s;
      pixel_level <= v;
      tick(1);
      line_reset_in <= 1'h1;
      tick(3);
      phase2_in <= 1'h0;
      tick(1);
      line_reset_in <= 1'h0;
      scan_start_pulse <= 1'h0;
      phase1_in <= 1'h1;
      tick(3);
   endtask
   task automatic scan(input int n, input int gap);
      period(gap, 1'h1, 8'h00);
      for (int i = 0; i < n; i++) period(gap, 1'h0, 8'hA0 + 8'(i));
   endtask
endmodule
`default_nettype wire
